/* File: rtl/ttc_capture.sv */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Alert stays low until the programmed count of consecutive out-of-window results.
// - Before-trigger mode writes every new result into the ring buffer until trigger.
// - Before-trigger trigger stops writes; buffer holds 15 earlier samples plus trigger.
// - After-trigger mode stores nothing into the buffer before the trigger.
// - After-trigger stores the trigger sample and 15 following, then stops at 16.
// - Alert is asserted toward the host when the trigger fires on the programmed count of consecutive out-of-window results.
// - Low comparator is set when a result is at or below the low threshold.
// - High comparator is set when a result is at or above the high threshold.
module ttc_capture (
    input  wire logic                      clk_sys_i,
    input  wire logic                      reset_n_i,
    input  wire ttc_pkg::ttc_cfg_t         cfg_i,
    input  wire logic                      arm_i,
    input  wire ttc_pkg::ttc_sample_t      sample_i,
    input  wire logic                      sample_valid_i,
    output logic                           sample_ready_o,
    input  wire logic [ttc_pkg::BUF_IDX_W-1:0] rd_index_i,
    output ttc_pkg::ttc_sample_t           rd_data_o,
    output logic                           alert_o,
    output logic                           low_cmp_o,
    output logic                           high_cmp_o,
    output logic                           capture_done_o,
    output logic [ttc_pkg::BUF_IDX_W-1:0]  oldest_index_o,
    output logic [4:0]                     fill_level_o
);
    import ttc_pkg::*;

    typedef enum logic [1:0] {
        TTC_ST_WATCH,
        TTC_ST_POST,
        TTC_ST_HOLD
    } ttc_state_t;

    ttc_state_t              state;
    ttc_sample_t             fifo_data;
    logic                    fifo_valid;
    logic                    conv;
    logic                    is_low;
    logic                    is_high;
    logic                    outside;
    logic                    trigger;
    logic                    buf_write;
    logic [CNT_W-1:0]        event_cnt;
    logic [CNT_W-1:0]        next_event_cnt;
    logic [BUF_IDX_W-1:0]    wr_idx;
    logic [4:0]              fill;
    ttc_sample_t             sample_buf [BUF_DEPTH];
    logic [BUF_DEPTH-1:0]    entry_valid;
    ttc_sample_t             rd_entry;

    // The FIFO decouples the conversion engine; it only drains while not holding.
    ttc_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .reset_n_i   (reset_n_i),
        .in_data_i   (sample_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (state != TTC_ST_HOLD)
    );

    assign conv    = fifo_valid && (state != TTC_ST_HOLD);
    assign is_low  = (fifo_data.code <= cfg_i.low_thr);
    assign is_high = (fifo_data.code >= cfg_i.high_thr);
    assign outside = is_low || is_high;

    always_comb begin
        next_event_cnt = event_cnt;
        if (!outside) begin
            next_event_cnt = CNT_RESET;
        end else if (event_cnt != cfg_i.event_count) begin
            next_event_cnt = event_cnt + CNT_W'(1);
        end
    end

    // A zero count behaves like one: the first out-of-window result triggers.
    assign trigger = conv && (state == TTC_ST_WATCH) && outside &&
                     ((next_event_cnt >= cfg_i.event_count) ||
                      (cfg_i.event_count == CNT_RESET));

    assign buf_write = conv && ((state == TTC_ST_POST) ||
                       (state == TTC_ST_WATCH &&
                        (cfg_i.mode == TTC_MODE_BEFORE || trigger)));

    // The counter only moves while watching; after the trigger its value no longer matters.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_cnt <= CNT_RESET;
        end else if (arm_i) begin
            event_cnt <= CNT_RESET;
        end else if (conv && state == TTC_ST_WATCH) begin
            event_cnt <= next_event_cnt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= TTC_ST_WATCH;
        end else if (arm_i) begin
            state <= TTC_ST_WATCH;
        end else begin
            case (state)
                TTC_ST_WATCH: begin
                    if (trigger) begin
                        state <= (cfg_i.mode == TTC_MODE_BEFORE) ? TTC_ST_HOLD
                                                                 : TTC_ST_POST;
                    end
                end
                TTC_ST_POST: begin
                    if (conv && fill == FILL_FULL - 5'h01) begin
                        state <= TTC_ST_HOLD;
                    end
                end
                TTC_ST_HOLD: begin
                    state <= TTC_ST_HOLD;
                end
                // The spare encoding returns to watching instead of locking the block up.
                default: begin
                    state <= TTC_ST_WATCH;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_idx <= IDX_RESET;
            fill   <= FILL_RESET;
        end else if (arm_i) begin
            wr_idx <= IDX_RESET;
            fill   <= FILL_RESET;
        end else if (buf_write) begin
            wr_idx <= wr_idx + BUF_IDX_W'(1);
            if (fill != FILL_FULL) begin
                fill <= fill + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (buf_write) begin
            sample_buf[wr_idx] <= fifo_data;
        end
    end

    // Each entry remembers whether it was written since the last restart, so a read of an
    // empty slot returns zero rather than a sample left over from an earlier capture.
    for (genvar e = 0; e < BUF_DEPTH; e++) begin : g_entry
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                entry_valid[e] <= 1'b0;
            end else if (arm_i) begin
                entry_valid[e] <= 1'b0;
            end else if (buf_write && wr_idx == BUF_IDX_W'(e)) begin
                entry_valid[e] <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_entry = '0;
        if (entry_valid[rd_index_i]) begin
            rd_entry = sample_buf[rd_index_i];
        end
    end

    // Alert is sticky, so a host that sleeps through many cycles still finds it set.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alert_o <= 1'b0;
        end else if (arm_i) begin
            alert_o <= 1'b0;
        end else if (trigger) begin
            alert_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_cmp_o  <= 1'b0;
            high_cmp_o <= 1'b0;
        end else if (conv) begin
            low_cmp_o  <= is_low;
            high_cmp_o <= is_high;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            capture_done_o <= 1'b0;
            oldest_index_o <= IDX_RESET;
            fill_level_o   <= FILL_RESET;
        end else begin
            capture_done_o <= (state == TTC_ST_HOLD);
            // Once wrapped, the next write slot is the oldest entry.
            oldest_index_o <= (fill == FILL_FULL) ? wr_idx : IDX_RESET;
            fill_level_o   <= fill;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= rd_entry;
        end
    end

endmodule : ttc_capture

`default_nettype wire

/* File: include/ttc_pkg.sv */
`default_nettype none
package ttc_pkg;

    localparam int unsigned DATA_W      = 12;
    localparam int unsigned CH_W        = 1;
    localparam int unsigned CNT_W       = 4;
    localparam int unsigned BUF_DEPTH   = 16;
    localparam int unsigned BUF_IDX_W   = 4;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam int unsigned SAMPLE_W    = DATA_W + CH_W;
    localparam int unsigned SYNC_STAGES = 3;

    localparam logic [BUF_IDX_W-1:0] IDX_RESET  = 4'h0;
    localparam logic [BUF_IDX_W-1:0] IDX_LAST   = 4'hf;
    localparam logic [4:0]           FILL_RESET = 5'h00;
    localparam logic [4:0]           FILL_FULL  = 5'h10;
    localparam logic [CNT_W-1:0]     CNT_RESET  = 4'h0;

    typedef enum logic {
        TTC_MODE_BEFORE,
        TTC_MODE_AFTER
    } ttc_mode_t;

    typedef struct packed {
        logic [CH_W-1:0]   chan;
        logic [DATA_W-1:0] code;
    } ttc_sample_t;

    typedef struct packed {
        logic [DATA_W-1:0] low_thr;
        logic [DATA_W-1:0] high_thr;
        logic [CNT_W-1:0]  event_count;
        ttc_mode_t         mode;
    } ttc_cfg_t;

endpackage : ttc_pkg

`default_nettype wire

/* File: rtl/ttc_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module ttc_fifo #(
    parameter int unsigned WIDTH = 13,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);

    localparam int unsigned PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
    logic [PTR_W:0]   next_count;
    logic             push;
    logic             pop;

    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign next_count  = count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

    // Ready is a flip-flop of its own, so no logic path reaches the ready pin.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr     <= '0;
            rd_ptr     <= '0;
            count      <= '0;
            in_ready_o <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + PTR_W'(1);
            end
            count      <= next_count;
            in_ready_o <= (next_count != (PTR_W+1)'(DEPTH));
        end
    end

    // Storage has no reset; only the pointers and the count decide what is valid.
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

endmodule : ttc_fifo

`default_nettype wire

/* File: test/ttc_capture_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module ttc_capture_monitor (
    input wire logic              clk_sys_i,
    input wire logic              reset_n_i,
    input wire ttc_pkg::ttc_cfg_t cfg_i,
    input wire logic              arm_i,
    input wire logic              alert_o,
    input wire logic              low_cmp_o,
    input wire logic              high_cmp_o,
    input wire logic              capture_done_o,
    input wire logic [4:0]        fill_level_o
);
    import ttc_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    a_alert_sticky: assert property (alert_o && !arm_i |=> alert_o)
        else $error("alert dropped without restart");
    a_alert_cause: assert property ($rose(alert_o) |-> low_cmp_o || high_cmp_o)
        else $error("alert raised by an in-window result");
    a_after_empty: assert property (cfg_i.mode == TTC_MODE_AFTER && !alert_o
        && !$past(arm_i) |-> fill_level_o == FILL_RESET)
        else $error("after mode stored before trigger");
    a_after_full: assert property (capture_done_o && cfg_i.mode == TTC_MODE_AFTER
        |-> fill_level_o == FILL_FULL) else $error("after mode stopped early");
    a_fill_max: assert property (fill_level_o <= FILL_FULL)
        else $error("fill level beyond buffer depth");
    a_fill_step: assert property (!$past(arm_i) && !$past(arm_i, 2)
        && $changed(fill_level_o) |-> fill_level_o == $past(fill_level_o) + 5'h01)
        else $error("fill level jumped");
    a_hold_frozen: assert property (capture_done_o && !arm_i && !$past(arm_i)
        |=> $stable(fill_level_o)) else $error("buffer written while holding");
    a_before_done: assert property ($rose(alert_o) && cfg_i.mode == TTC_MODE_BEFORE
        |-> ##[0:2] capture_done_o) else $error("before mode kept writing after trigger");
endmodule : ttc_capture_monitor

bind ttc_capture ttc_capture_monitor u_mon (.clk_sys_i, .reset_n_i, .cfg_i, .arm_i, .alert_o,
    .low_cmp_o, .high_cmp_o, .capture_done_o, .fill_level_o);
`default_nettype wire

/* File: test/ttc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ttc_host_model (
    input  wire logic                 clk_sys_i,
    input  wire logic                 alert_i,
    input  wire ttc_pkg::ttc_sample_t rd_data_i,
    output logic [3:0]                rd_index_o
);
    import ttc_pkg::*;
    int alerts = 0;
    initial rd_index_o = 4'h0;
    // The host wakes on each alert edge; a missed edge would leave it asleep.
    always @(posedge alert_i) alerts++;
    task automatic fetch(input logic [3:0] idx, output ttc_sample_t d);
        rd_index_o = idx;
        @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        #1 d = rd_data_i;
    endtask : fetch
endmodule : ttc_host_model
`default_nettype wire

/* File: test/threshold_triggered_sample_capture_test.sv */
`timescale 1ns/100ps
`default_nettype none
module threshold_triggered_sample_capture_test;
    import ttc_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        arm       = 1'b0;
    logic        vld       = 1'b0;
    ttc_cfg_t    cfg       = '{12'h064, 12'h0c8, 4'h3, TTC_MODE_BEFORE};
    ttc_sample_t smp       = '0;
    ttc_sample_t rd_data;
    logic        rdy, alert, lo, hi, done;
    logic [3:0]  rd_idx, oldest;
    logic [4:0]  fill;
    logic [11:0] q[$];
    int          mismatches = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    ttc_capture uut (.clk_sys_i, .reset_n_i, .cfg_i(cfg), .arm_i(arm), .sample_i(smp),
        .sample_valid_i(vld), .sample_ready_o(rdy), .rd_index_i(rd_idx), .rd_data_o(rd_data),
        .alert_o(alert), .low_cmp_o(lo), .high_cmp_o(hi), .capture_done_o(done),
        .oldest_index_o(oldest), .fill_level_o(fill));
    ttc_host_model host (.clk_sys_i, .alert_i(alert), .rd_data_i(rd_data), .rd_index_o(rd_idx));
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Spaced sends let each result settle before it is judged.
    task automatic send(input logic [11:0] code);
        smp = '{1'b0, code};
        vld = 1'b1;
        while (rdy !== 1'b1) @(posedge clk_sys_i) #1;
        @(posedge clk_sys_i) #1 vld = 1'b0;
        q.push_back(code);
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask : send
    task automatic run_before();
        ttc_sample_t d;
        for (int i = 0; i < 20; i++) send(12'h070 + 12'(i));
        send(12'h064);
        check(lo, 1);
        send(12'h065);
        check(lo, 0);
        send(12'h0c8);
        check(hi, 1);
        send(12'h0c9);
        check(alert, 0);
        send(12'h080);
        send(12'h0c8);
        send(12'h0c9);
        check(alert, 0);
        send(12'h0ca);
        check(alert, 1);
        check(fill, 16);
        check(oldest, q.size() % 16);
        for (int k = 0; k < 16; k++) begin
            host.fetch(oldest + 4'(k), d);
            check(d.code, q[q.size() - 16 + k]);
        end
    endtask : run_before
    task automatic run_after();
        ttc_sample_t d;
        arm = 1'b1;
        @(posedge clk_sys_i) #1 arm = 1'b0;
        cfg.mode = TTC_MODE_AFTER;
        cfg.event_count = 4'h1;
        for (int i = 0; i < 5; i++) send(12'h070 + 12'(i));
        check(fill, 0);
        host.fetch(4'h0, d);
        check(d, 16'h0000);
        send(12'h0d0);
        check(alert, 1);
        for (int i = 1; i < 24; i++) send(12'h070 + 12'(i));
        check(fill, 16);
        check(done, 1);
        vld = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1 check(rdy, 0);
        vld = 1'b0;
        for (int k = 0; k < 16; k++) begin
            host.fetch(4'(k), d);
            check(d.code, k == 0 ? 12'h0d0 : 12'h070 + 12'(k));
        end
        check(host.alerts, 2);
    endtask : run_after
    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1 reset_n_i = 1'b1;
        run_before();
        run_after();
        print_verdict();
    end
endmodule : threshold_triggered_sample_capture_test
`default_nettype wire
